/* verif/scnps_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host controller model: turns bench requests into the engine's input pin levels.
module scnps_host_model (
  // Clock for the floating-pin pattern.
  input wire logic clk,
  // Requests from the bench, active high.
  input wire logic trig_req,
  input wire logic wake_req,
  input wire logic cts_req,
  input wire logic boot_ok,
  input wire logic usb_mode,
  // Engine pins that the host sees.
  input wire logic txd_pin,
  input wire logic cts_usbp_o,
  input wire logic cts_usbp_oe_n,
  input wire logic rxd_usbm_o,
  input wire logic rxd_usbm_oe_n,
  // Pin levels into the engine.
  output scnps_pkg::scnps_pins_s pins
);
  import scnps_pkg::*;

  // Flips each cycle so an undriven shared pin never keeps a stale level.
  logic float_q = 1'b0;

  // The pattern register.
  always_ff @(posedge clk)
  begin
    float_q <= ~float_q;
  end

  // Host pin levels; serial receive loops back the engine's transmit line.
  assign pins = '{
    trigger_n: ~trig_req,
    wake_n: ~wake_req,
    boot: boot_ok,
    usb_sel: usb_mode,
    cts_usbp: usb_mode ? (cts_usbp_oe_n ? float_q : cts_usbp_o) : ~cts_req,
    rxd_usbm: usb_mode ? (rxd_usbm_oe_n ? ~float_q : rxd_usbm_o) : txd_pin
  };
endmodule : scnps_host_model

`default_nettype wire

/* verif/tb_scan_engine_power_state_pins.sv */
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the power-state and host-pin block.
module tb_scan_engine_power_state_pins;
  import scnps_pkg::*;

  // Shortened timeout and pulse lengths.
  localparam int TMO = 50;
  localparam int HOLD = 4;
  // Clock, reset, decoder-side and core-side inputs.
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic lp_off = 1'b0;
  logic lp_on = 1'b0;
  logic read_ok = 1'b0;
  logic beep = 1'b0;
  logic s_rts = 1'b1;
  logic s_txd = 1'b1;
  scnps_usb_drv_s usb_drv = '0;
  // Host requests; boot starts low to hold the engine at power-on.
  logic trig = 1'b0;
  logic wake = 1'b0;
  logic cts = 1'b0;
  logic boot = 1'b0;
  logic usb = 1'b0;
  // Engine pins and outputs.
  scnps_pins_s pins;
  scnps_state_e st;
  logic ind_n, buz_n, pdn, rts_pin, txd_pin, cp_o, cp_oe_n;
  logic rm_o, rm_oe_n, s_rxd, s_cts, dp_rx, dm_rx;
  // Counters and random state.
  int num_errors = 0;
  int checks_done = 0;
  logic [15:0] lfsr_q = 16'h73EC;

  // Free-running clock.
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  scnps_top #(.TIMEOUT_CYCLES(TMO), .LED_CYCLES(HOLD), .BEEP_CYCLES(HOLD)) dut_u (
    .clk(clk), .resetn(resetn), .pins_in(pins), .cmd_low_power_off(lp_off),
    .cmd_low_power_on(lp_on), .read_ok(read_ok), .beep(beep), .serial_rts(s_rts),
    .serial_txd(s_txd), .usb_drv(usb_drv), .read_ok_indicator(ind_n), .buzzer_n(buz_n),
    .power_down(pdn), .rts_pin(rts_pin), .txd_pin(txd_pin), .cts_usbp_o(cp_o),
    .cts_usbp_oe_n(cp_oe_n), .rxd_usbm_o(rm_o), .rxd_usbm_oe_n(rm_oe_n),
    .serial_rxd(s_rxd), .serial_cts(s_cts), .usb_dp_rx(dp_rx), .usb_dm_rx(dm_rx),
    .power_state(st));

  scnps_host_model host_u (
    .clk(clk), .trig_req(trig), .wake_req(wake), .cts_req(cts), .boot_ok(boot),
    .usb_mode(usb), .txd_pin(txd_pin), .cts_usbp_o(cp_o), .cts_usbp_oe_n(cp_oe_n),
    .rxd_usbm_o(rm_o), .rxd_usbm_oe_n(rm_oe_n), .pins(pins));

  // Next value of the pseudo-random sequence.
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  // Expected shared-pin drive: USB core copy in USB mode, released in serial mode.
  function automatic logic [3:0] exp_shared(input logic m, input scnps_usb_drv_s d);
    return m ? {d.dp, d.dp_oe_n, d.dm, d.dm_oe_n} : 4'h5;
  endfunction : exp_shared

  // Compares one value with its expectation and counts the result.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // Waits n rising edges, then lets their updates settle.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Raises {lp_off, lp_on, read_ok, beep} for exactly one sampling edge.
  task automatic pulse(input logic [3:0] v);
    {lp_off, lp_on, read_ok, beep} <= v;
    step(1);
    {lp_off, lp_on, read_ok, beep} <= 4'h0;
  endtask : pulse

  // Counts edges until the state is reached, giving up after 300.
  task automatic wait_state(input scnps_state_e s, output int n);
    n = 0;
    while (st !== s && n < 300)
    begin
      step(1);
      n++;
    end
  endtask : wait_state

  // Checks that a read-ok or beep request gives a low level of HOLD + 1 cycles.
  task automatic hold_chk(input logic is_beep);
    pulse(is_beep ? 4'h1 : 4'h2);
    check(is_beep ? buz_n : ind_n, 1'b0);
    step(HOLD);
    check(is_beep ? buz_n : ind_n, 1'b0);
    step(1);
    check(is_beep ? buz_n : ind_n, 1'b1);
  endtask : hold_chk

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Watchdog in case a wait hangs.
  initial
  begin
    step(20000);
    $display("Watchdog expired");
    num_errors++;
    conclude();
  end

  // Main sequence.
  initial
  begin
    int n;
    step(3);
    resetn <= 1'b1;
    // Boot low holds power-on while low power is enabled.
    pulse(4'h4);
    step(6);
    check(st, SCNPS_ST_PWRON);
    boot <= 1'b1;
    repeat (5)
    begin
      step(1);
      check(st === SCNPS_ST_IDLE, 1'b0);
    end
    check(st, SCNPS_ST_SLEEP);
    check(pdn, 1'b1);
    // Wake pin leaves SLEEP, then the quiet timer returns to it.
    wake <= 1'b1;
    wait_state(SCNPS_ST_IDLE, n);
    check(n <= 4, 1'b1);
    step(1);
    check(pdn, 1'b0);
    wake <= 1'b0;
    step(20);
    pulse(4'h2);
    wait_state(SCNPS_ST_SLEEP, n);
    check(n, TMO);
    // Clear-to-send wakes; trigger reads and holds off the timeout.
    cts <= 1'b1;
    wait_state(SCNPS_ST_IDLE, n);
    check(n <= 4, 1'b1);
    cts <= 1'b0;
    trig <= 1'b1;
    wait_state(SCNPS_ST_READ, n);
    check(n <= 4, 1'b1);
    step(TMO + 5);
    check(st, SCNPS_ST_READ);
    trig <= 1'b0;
    wait_state(SCNPS_ST_IDLE, n);
    check(st, SCNPS_ST_IDLE);
    hold_chk(1'b0);
    hold_chk(1'b1);
    // Disable command stops sleeping; enable restarts the timer.
    pulse(4'h8);
    step(TMO + 10);
    check(st, SCNPS_ST_IDLE);
    pulse(4'h4);
    wait_state(SCNPS_ST_SLEEP, n);
    check(n, TMO);
    // Random pin traffic, serial mode first, then USB mode.
    for (int i = 0; i < 40; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      usb <= (i >= 20);
      s_rts <= lfsr_q[0];
      s_txd <= lfsr_q[1];
      usb_drv <= lfsr_q[5:2];
      cts <= lfsr_q[6] && (i < 20);
      step(6);
      check(rts_pin, usb ? 1'b1 : s_rts);
      check(txd_pin, usb ? 1'b1 : s_txd);
      check({cp_o, cp_oe_n, rm_o, rm_oe_n}, exp_shared(usb, usb_drv));
      check(s_cts, usb ? 1'b1 : !cts);
      check(s_rxd, usb ? 1'b1 : s_txd);
      if (usb && !usb_drv.dp_oe_n)
        check(dp_rx, usb_drv.dp);
      if (usb && !usb_drv.dm_oe_n)
        check(dm_rx, usb_drv.dm);
      if (!usb)
        check({dp_rx, dm_rx}, 2'h0);
    end
    step(TMO + 10);
    check(st, SCNPS_ST_IDLE);
    // Second reset: low power is off by default.
    usb <= 1'b0;
    resetn <= 1'b0;
    step(3);
    resetn <= 1'b1;
    step(TMO + 10);
    check(st, SCNPS_ST_IDLE);
    check(pdn, 1'b0);
    conclude();
  end
endmodule : tb_scan_engine_power_state_pins

`default_nettype wire

/* verilog/placeholder_unused_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* verilog/scnps_pkg.sv */
`default_nettype none

// Shared types of the power-state and host-pin block.
package scnps_pkg;

  // Power states of the engine.
  typedef enum logic [1:0]
  {
    SCNPS_ST_PWRON,
    SCNPS_ST_SLEEP,
    SCNPS_ST_IDLE,
    SCNPS_ST_READ
  } scnps_state_e;

  // Raw levels of the host-facing input pins.
  typedef struct packed
  {
    logic trigger_n;
    logic wake_n;
    logic boot;
    logic usb_sel;
    logic cts_usbp;
    logic rxd_usbm;
  } scnps_pins_s;

  // Drive requests of the USB core for the two shared data pins.
  typedef struct packed
  {
    logic dp;
    logic dp_oe_n;
    logic dm;
    logic dm_oe_n;
  } scnps_usb_drv_s;

endpackage : scnps_pkg

`default_nettype wire

/* verilog/scnps_regs.svh */
`ifndef SCNPS_REGS_SVH
`define SCNPS_REGS_SVH

// Clock rate in kHz and in MHz, used to turn times into cycle counts.
`define SCNPS_CLK_KHZ 40000
`define SCNPS_CLK_MHZ 40

// Quiet time in IDLE before falling back to SLEEP, in milliseconds.
`define SCNPS_IDLE_TIMEOUT_MS 2000
// The same quiet time as a count of clock cycles.
`define SCNPS_IDLE_TIMEOUT_CYC (`SCNPS_IDLE_TIMEOUT_MS * `SCNPS_CLK_KHZ)

// Hold time of the read-ok indicator after a good read, in microseconds.
`define SCNPS_LED_HOLD_US 100
// The same hold time as a count of clock cycles.
`define SCNPS_LED_HOLD_CYC (`SCNPS_LED_HOLD_US * `SCNPS_CLK_MHZ)

// Length of one buzzer pulse, in microseconds.
`define SCNPS_BEEP_US 100
// The same pulse length as a count of clock cycles.
`define SCNPS_BEEP_CYC (`SCNPS_BEEP_US * `SCNPS_CLK_MHZ)

// Low-power setting after reset: disabled.
`define SCNPS_LP_EN_RST 1'b0

`endif

/* verilog/scnps_stretch.sv */
`timescale 1ns/1ps
`default_nettype none

// Stretches a one-cycle request into an active-low level of fixed length.
module scnps_stretch #(
  parameter int unsigned CYCLES = 4000
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Request and stretched output.
  input wire logic start,
  output logic active_n_q
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt_q; // Cycles of the pulse still to run.
  logic [CW-1:0] cnt_d; // Next value of the counter.
  logic active_n_d; // Next level of the output.

  // A new request restarts the pulse; otherwise the count runs down.
  assign cnt_d = start ? LOAD : ((cnt_q != '0) ? cnt_q - ONE : cnt_q);
  assign active_n_d = !(start || (cnt_q > ONE));

  // Counter and output register, both idle after reset.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt_q <= '0;
      active_n_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      active_n_q <= active_n_d;
    end
  end

endmodule : scnps_stretch

`default_nettype wire

/* verilog/scnps_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scnps_regs.svh"

// Notes on behaviour
// - Low power only with the serial interface.
// - Low power on: power-on goes straight to SLEEP.
// - SLEEP leaves for IDLE on CTS or wake.
// - Two quiet seconds in IDLE return to SLEEP.
// - Commands disable (default) or enable low power.
// - Trigger is active low and starts reading.
// - Wake is active low.
// - Read-ok indicator low means on.
// - Buzzer pulse output low means sounding.
// - Power-down output high only in low power.
// - One pin: CTS in serial, USB plus in USB.
// - One pin: RXD in serial, USB minus in USB.
// - Serial mode drives RTS and TXD out.
module scnps_top #(
  parameter int unsigned TIMEOUT_CYCLES = `SCNPS_IDLE_TIMEOUT_CYC,
  parameter int unsigned LED_CYCLES = `SCNPS_LED_HOLD_CYC,
  parameter int unsigned BEEP_CYCLES = `SCNPS_BEEP_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Host pins in, raw and asynchronous.
  input wire scnps_pkg::scnps_pins_s pins_in,
  // Requests from the decoder on this clock.
  input wire logic cmd_low_power_off,
  input wire logic cmd_low_power_on,
  input wire logic read_ok,
  input wire logic beep,
  // Serial core outputs on this clock.
  input wire logic serial_rts,
  input wire logic serial_txd,
  // USB core drive requests on this clock.
  input wire scnps_pkg::scnps_usb_drv_s usb_drv,
  // Indicator, buzzer and power-down pins.
  output logic read_ok_indicator,
  output logic buzzer_n,
  output logic power_down,
  // Serial handshake and data pins.
  output logic rts_pin,
  output logic txd_pin,
  // Shared CTS / USB plus pin.
  output logic cts_usbp_o,
  output logic cts_usbp_oe_n,
  // Shared RXD / USB minus pin.
  output logic rxd_usbm_o,
  output logic rxd_usbm_oe_n,
  // Received levels handed to the cores.
  output logic serial_rxd,
  output logic serial_cts,
  output logic usb_dp_rx,
  output logic usb_dm_rx,
  // Current power state.
  output scnps_pkg::scnps_state_e power_state
);

  import scnps_pkg::*;

  localparam logic [31:0] TMO_LAST = 32'(TIMEOUT_CYCLES - 1);

  scnps_pins_s sync1_q; // First synchroniser stage, read only by the second.
  scnps_pins_s sync_q; // Synchronised pin levels.
  scnps_state_e state_q; // Power state register.
  scnps_state_e state_d; // Next power state.
  logic lp_en_q; // Low-power setting from the commands.
  logic lp_en_d; // Next low-power setting.
  logic [31:0] timer_q; // Quiet-time counter in IDLE.
  logic [31:0] timer_d; // Next quiet-time count.
  logic led_n; // Stretched indicator level.
  logic buzz_n; // Stretched buzzer level.

  // Output pin registers; each output port except power_state reads exactly one of them.
  logic pwr_down_q;
  logic led_q;
  logic buzz_q;
  logic rts_q;
  logic txd_q;
  logic dp_o_q;
  logic dp_oe_n_q;
  logic dm_o_q;
  logic dm_oe_n_q;
  logic srx_q;
  logic scts_q;
  logic dprx_q;
  logic dmrx_q;

  // Decoded, active-high meaning of the synchronised pins, commands, timer and state.
  wire usb_mode = sync_q.usb_sel;
  wire trig_act = !sync_q.trigger_n;
  wire wake_act = !sync_q.wake_n;
  wire cts_act = !usb_mode && !sync_q.cts_usbp;
  wire boot_ok = sync_q.boot;
  wire lp_active = lp_en_q && !usb_mode;
  wire any_cmd = cmd_low_power_off || cmd_low_power_on;
  wire event_any = trig_act || wake_act || cts_act || read_ok || any_cmd;
  wire timeout = (timer_q >= TMO_LAST);
  wire in_sleep = (state_q == SCNPS_ST_SLEEP);

  // Enable wins when both commands arrive together.
  assign lp_en_d = cmd_low_power_on ? 1'b1 : (cmd_low_power_off ? 1'b0 : lp_en_q);

  // Quiet timer runs only in IDLE with low power active.
  assign timer_d = (state_q != SCNPS_ST_IDLE || !lp_active || event_any) ? 32'h0
    : (timeout ? timer_q : timer_q + 32'h1);

  // Next-state decode of the power sequencer.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SCNPS_ST_PWRON:
      begin
        // Boot low holds the engine in power-on.
        if (boot_ok)
        begin
          state_d = lp_active ? SCNPS_ST_SLEEP : SCNPS_ST_IDLE;
        end
      end
      SCNPS_ST_SLEEP:
      begin
        // Wake or CTS, or losing low power, brings the engine up.
        if (cts_act || wake_act || !lp_active)
        begin
          state_d = SCNPS_ST_IDLE;
        end
      end
      SCNPS_ST_IDLE:
      begin
        // Trigger beats the timeout.
        if (trig_act)
        begin
          state_d = SCNPS_ST_READ;
        end
        else if (lp_active && timeout && !event_any)
        begin
          state_d = SCNPS_ST_SLEEP;
        end
      end
      SCNPS_ST_READ:
      begin
        // Reading lasts while the trigger is held low.
        if (!trig_act)
        begin
          state_d = SCNPS_ST_IDLE;
        end
      end
      default:
      begin
        state_d = SCNPS_ST_PWRON;
      end
    endcase
  end

  // Two-flop synchroniser for all host input pins.
  // Boot resets low so that power-on waits for the real boot level,
  // instead of leaving power-on on a reset value.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sync1_q <= '{trigger_n: 1'b1, wake_n: 1'b1, boot: 1'b0, usb_sel: 1'b0,
                   cts_usbp: 1'b1, rxd_usbm: 1'b1};
      sync_q <= '{trigger_n: 1'b1, wake_n: 1'b1, boot: 1'b0, usb_sel: 1'b0,
                  cts_usbp: 1'b1, rxd_usbm: 1'b1};
    end
    else
    begin
      sync1_q <= pins_in;
      sync_q <= sync1_q;
    end
  end

  // Sequencer state, low-power setting and quiet timer.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_q <= SCNPS_ST_PWRON;
      lp_en_q <= `SCNPS_LP_EN_RST;
      timer_q <= 32'h0;
    end
    else
    begin
      state_q <= state_d;
      lp_en_q <= lp_en_d;
      timer_q <= timer_d;
    end
  end

  // Indicator pulse stretcher.
  scnps_stretch #(
    .CYCLES(LED_CYCLES)
  ) u_led (
    .clk(clk),
    .resetn(resetn),
    .start(read_ok),
    .active_n_q(led_n)
  );

  // Buzzer pulse stretcher.
  scnps_stretch #(
    .CYCLES(BEEP_CYCLES)
  ) u_beep (
    .clk(clk),
    .resetn(resetn),
    .start(beep),
    .active_n_q(buzz_n)
  );

  // Output pin registers; the shared pins follow the selected interface.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pwr_down_q <= 1'b0;
      led_q <= 1'b1;
      buzz_q <= 1'b1;
      rts_q <= 1'b1;
      txd_q <= 1'b1;
      dp_o_q <= 1'b0;
      dp_oe_n_q <= 1'b1;
      dm_o_q <= 1'b0;
      dm_oe_n_q <= 1'b1;
      srx_q <= 1'b1;
      scts_q <= 1'b1;
      dprx_q <= 1'b0;
      dmrx_q <= 1'b0;
    end
    else
    begin
      pwr_down_q <= in_sleep;
      led_q <= led_n && !read_ok;
      buzz_q <= buzz_n && !beep;
      rts_q <= usb_mode ? 1'b1 : serial_rts;
      txd_q <= usb_mode ? 1'b1 : serial_txd;
      dp_o_q <= usb_mode ? usb_drv.dp : 1'b0;
      dp_oe_n_q <= usb_mode ? usb_drv.dp_oe_n : 1'b1;
      dm_o_q <= usb_mode ? usb_drv.dm : 1'b0;
      dm_oe_n_q <= usb_mode ? usb_drv.dm_oe_n : 1'b1;
      srx_q <= usb_mode ? 1'b1 : sync_q.rxd_usbm;
      scts_q <= usb_mode ? 1'b1 : sync_q.cts_usbp;
      dprx_q <= usb_mode ? sync_q.cts_usbp : 1'b0;
      dmrx_q <= usb_mode ? sync_q.rxd_usbm : 1'b0;
    end
  end

  // Port connections, all straight from registers.
  assign read_ok_indicator = led_q;
  assign buzzer_n = buzz_q;
  assign power_down = pwr_down_q;
  assign rts_pin = rts_q;
  assign txd_pin = txd_q;
  assign cts_usbp_o = dp_o_q;
  assign cts_usbp_oe_n = dp_oe_n_q;
  assign rxd_usbm_o = dm_o_q;
  assign rxd_usbm_oe_n = dm_oe_n_q;
  assign serial_rxd = srx_q;
  assign serial_cts = scts_q;
  assign usb_dp_rx = dprx_q;
  assign usb_dm_rx = dmrx_q;
  assign power_state = state_q;

  // Checks on the sequencer and the pins.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // A wake from SLEEP, one cycle later in IDLE.
  sequence s_wake_req;
    in_sleep && lp_active && (cts_act || wake_act);
  endsequence

  sequence s_in_idle;
    state_q == SCNPS_ST_IDLE;
  endsequence

  a_sleep_needs_lp: assert property (in_sleep |-> $past(lp_active))
    else $error("SLEEP entered without low power active");
  a_poweron_to_sleep: assert property (
    (state_q == SCNPS_ST_PWRON && lp_active && boot_ok) |=> in_sleep)
    else $error("power-on did not go to SLEEP");
  a_sleep_wakes: assert property (s_wake_req |=> s_in_idle)
    else $error("SLEEP did not wake to IDLE");
  a_idle_timeout: assert property (
    (state_q == SCNPS_ST_IDLE && lp_active && timer_q == TMO_LAST && !event_any
     && !trig_act) |=> in_sleep)
    else $error("IDLE did not time out to SLEEP");
  a_idle_no_early: assert property (
    (state_q == SCNPS_ST_IDLE && !in_sleep) ##1 in_sleep |-> $past(timer_q) == TMO_LAST)
    else $error("SLEEP re-entered before the quiet time ran out");
  a_timer_restart: assert property (event_any |=> timer_q == 32'h0)
    else $error("event did not restart the quiet timer");
  a_cmd_on: assert property (cmd_low_power_on |=> lp_en_q)
    else $error("enable command not taken");
  a_cmd_off: assert property ((cmd_low_power_off && !cmd_low_power_on) |=> !lp_en_q)
    else $error("disable command not taken");
  a_trigger_read: assert property (
    (state_q == SCNPS_ST_IDLE && trig_act) |=> state_q == SCNPS_ST_READ)
    else $error("trigger did not start a read");
  a_wake_pin: assert property (
    (in_sleep && lp_active && !sync_q.wake_n) |=> !in_sleep)
    else $error("low wake pin did not wake");
  a_led_on: assert property (read_ok |=> !read_ok_indicator [*2])
    else $error("indicator not driven low after a good read");
  a_buzz_on: assert property (beep |=> !buzzer_n)
    else $error("buzzer not driven low after a beep request");
  a_power_down: assert property (power_down == $past(in_sleep))
    else $error("power-down pin does not follow SLEEP");
  a_serial_pins: assert property (
    (!usb_mode && $past(!usb_mode)) |-> (cts_usbp_oe_n && rxd_usbm_oe_n))
    else $error("shared pins driven in serial mode");
  a_serial_tx: assert property (
    !usb_mode |=> (txd_pin == $past(serial_txd) && rts_pin == $past(serial_rts)))
    else $error("serial outputs do not follow the serial core");
  a_usb_rx: assert property (
    usb_mode |=> usb_dm_rx == $past(sync_q.rxd_usbm))
    else $error("USB minus level not handed to the USB core");

endmodule : scnps_top

`default_nettype wire
